/* File: hw/tpc_top.sv */
`timescale 1ns/1ps
module tpc_top (
    input  wire logic                       mclk_i,
    input  wire logic                       rst_i,
    input  wire logic                       step_up_i,
    input  wire logic                       step_dn_i,
    input  wire logic                       hold_n_i,
    input  wire logic                       res_select_a_i,
    input  wire logic                       res_select_b_i,
    input  wire logic [tpc_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [tpc_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    output logic      [tpc_pkg::DATA_W-1:0] rdata_o,
    output logic      [tpc_pkg::POS_W-1:0]  position_bits_o,
    output logic                            busy_o,
    output logic                            carry_pulse_out_o,
    output logic                            dir_o,
    output logic                            irq_o
);
    logic [4:0]                 sync_q;
    logic                       up_q;
    logic                       dn_q;
    logic                       hold_q;
    logic [1:0]                 res_q;
    logic                       up_prev_ff;
    logic                       dn_prev_ff;
    logic                       hold_prev_ff;
    logic [tpc_pkg::POS_W-1:0]  cnt_ff;
    logic [tpc_pkg::POS_W-1:0]  nxt_cnt;
    logic [tpc_pkg::POS_W-1:0]  res_mask_ff;
    logic [tpc_pkg::POS_W-1:0]  latch_ff;
    logic                       carry_req_ff;
    logic                       busy_req;
    logic                       dir_chg;
    logic [tpc_pkg::ST_W-1:0]   status_ff;
    logic [tpc_pkg::ST_W-1:0]   irq_mask_ff;
    logic [tpc_pkg::ST_W-1:0]   ev;
    tpc_pkg::tpc_step_t         stp;
    tpc_pkg::tpc_bus_req_t      req;

    assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

    // step, hold and select pins cross into the clock domain first; bus pins go in directly
    tpc_sync #(.W(5)) u_sync (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .d_i    ({step_up_i, step_dn_i, hold_n_i,
                  res_select_b_i, res_select_a_i}),
        .q_o    (sync_q)
    );
    assign up_q   = sync_q[4];
    assign dn_q   = sync_q[3];
    assign hold_q = sync_q[2];
    assign res_q  = sync_q[1:0];

    // edge history of synchronised pins; kept running through reset
    // so the idle levels never show up as an edge after it
    always_ff @(posedge mclk_i) begin
        up_prev_ff   <= up_q;
        dn_prev_ff   <= dn_q;
        hold_prev_ff <= hold_q;
    end

    // decode one step; coincident up and down cancel out
    always_comb begin
        stp.up   = up_q & ~up_prev_ff;
        stp.step = stp.up ^ (dn_q & ~dn_prev_ff);
        stp.wrap = stp.up ? (cnt_ff == res_mask_ff) : (cnt_ff == '0);
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            res_mask_ff <= tpc_pkg::MASK_10;
        end else begin
            case (res_q)
                tpc_pkg::RES_10: res_mask_ff <= tpc_pkg::MASK_10;
                tpc_pkg::RES_12: res_mask_ff <= tpc_pkg::MASK_12;
                tpc_pkg::RES_14: res_mask_ff <= tpc_pkg::MASK_14;
                tpc_pkg::RES_16: res_mask_ff <= tpc_pkg::MASK_16;
                default:         res_mask_ff <= tpc_pkg::MASK_16;
            endcase
        end
    end

    // plain binary wrapping at full scale
    always_comb begin
        nxt_cnt = cnt_ff;
        if (stp.step && stp.up) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (stp.step) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
        // masking also trims the count after a width change
        nxt_cnt = nxt_cnt & res_mask_ff;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cnt_ff <= tpc_pkg::POS_RST;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            dir_o <= 1'b1;
        end else if (stp.step) begin
            dir_o <= stp.up;
        end
    end
    assign dir_chg = stp.step & (stp.up != dir_o);

    // one cycle behind direction, so direction settles first
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            carry_req_ff <= 1'b0;
        end else begin
            carry_req_ff <= stp.step & stp.wrap;
        end
    end

    tpc_stretch #(.CYC(tpc_pkg::CARRY_CYC)) u_carry (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .trig_i  (carry_req_ff),
        .pulse_o (carry_pulse_out_o)
    );

    // busy also refreshes latch on hold release
    assign busy_req = stp.step | (hold_q & ~hold_prev_ff);
    tpc_stretch #(.CYC(tpc_pkg::BUSY_CYC)) u_busy (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .trig_i  (busy_req),
        .pulse_o (busy_o)
    );

    // output latch follows only while hold high
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            latch_ff <= tpc_pkg::POS_RST;
        end else if (hold_q) begin
            latch_ff <= cnt_ff;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            position_bits_o <= tpc_pkg::POS_RST;
        end else begin
            position_bits_o <= latch_ff & res_mask_ff;
        end
    end

    // sticky events; a new event beats a same-cycle clear
    always_comb begin
        ev = '0;
        ev[tpc_pkg::ST_STEP]  = stp.step;
        ev[tpc_pkg::ST_CARRY] = carry_req_ff;
        ev[tpc_pkg::ST_DIRCH] = dir_chg;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            status_ff <= '0;
        end else if (req.wr && req.addr == tpc_pkg::OFS_STATUS) begin
            status_ff <= (status_ff & ~req.wdata[tpc_pkg::ST_W-1:0]) | ev;
        end else begin
            status_ff <= status_ff | ev;
        end
    end

    // interrupt mask
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            irq_mask_ff <= tpc_pkg::MASK_RST;
        end else if (req.wr && req.addr == tpc_pkg::OFS_MASK) begin
            irq_mask_ff <= req.wdata[tpc_pkg::ST_W-1:0];
        end
    end

    // level interrupt from unmasked sticky bits
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_ff & irq_mask_ff);
        end
    end

    // read data for one cycle only; unmapped reads give zero
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else if (req.rd) begin
            case (req.addr)
                tpc_pkg::OFS_STATUS:
                    rdata_o <= {13'h0000, status_ff};
                tpc_pkg::OFS_MASK:
                    rdata_o <= {13'h0000, irq_mask_ff};
                tpc_pkg::OFS_COUNT:
                    rdata_o <= cnt_ff;
                tpc_pkg::OFS_LATCH:
                    rdata_o <= latch_ff & res_mask_ff;
                tpc_pkg::OFS_INFO:
                    rdata_o <= {12'h000, hold_q, dir_o, res_q};
                default:
                    rdata_o <= '0;
            endcase
        end else begin
            rdata_o <= '0;
        end
    end

    // helper: length of current carry pulse
    logic [tpc_pkg::STR_W-1:0] carry_len_ff;
    always_ff @(posedge mclk_i) begin
        if (rst_i || !carry_pulse_out_o) begin
            carry_len_ff <= '0;
        end else if (carry_len_ff != '1) begin
            carry_len_ff <= carry_len_ff + 1'b1;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence s_up_step;
        stp.step && stp.up && !stp.wrap;
    endsequence

    sequence s_wrap_step;
        stp.step && stp.wrap;
    endsequence

    property p_count_up;
        s_up_step |=> cnt_ff == $past(cnt_ff) + 16'h0001;
    endproperty
    a_count_up: assert property (p_count_up)
        else $error("counter did not step up by one");

    property p_busy_pulse;
        stp.step |=> busy_o [*8];
    endproperty
    a_busy_pulse: assert property (p_busy_pulse)
        else $error("step without busy pulse");

    property p_busy_drop;
        $fell(busy_o) |-> $past(busy_req, 1) == 1'b0;
    endproperty
    a_busy_drop: assert property (p_busy_drop)
        else $error("busy ended while a step was pending");

    property p_wrap_carry;
        s_wrap_step |-> ##2 carry_pulse_out_o;
    endproperty
    a_wrap_carry: assert property (p_wrap_carry)
        else $error("wrap gave no carry pulse");

    property p_carry_len;
        $fell(carry_pulse_out_o) |->
            carry_len_ff >= 8'(tpc_pkg::CARRY_CYC);
    endproperty
    a_carry_len: assert property (p_carry_len)
        else $error("carry pulse too short");

    property p_dir_first;
        $rose(carry_pulse_out_o) |-> $stable(dir_o);
    endproperty
    a_dir_first: assert property (p_dir_first)
        else $error("direction moved with carry edge");

    property p_dir_latch;
        !stp.step |=> $stable(dir_o);
    endproperty
    a_dir_latch: assert property (p_dir_latch)
        else $error("direction changed without a step");

    property p_hold_freeze;
        !hold_q |=> $stable(latch_ff);
    endproperty
    a_hold_freeze: assert property (p_hold_freeze)
        else $error("latch updated while held");

    property p_unused_low;
        ##1 (position_bits_o & ~$past(res_mask_ff)) == 16'h0000;
    endproperty
    a_unused_low: assert property (p_unused_low)
        else $error("unused position line high");

    property p_irq_level;
        ##1 irq_o == $past(|(status_ff & irq_mask_ff));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level mismatch");
endmodule // tpc_top

/* File: hw/tpc_pkg.sv */
package tpc_pkg;
    // timing base
    localparam int CLK_MHZ   = 200;
    localparam int BUSY_NS   = 200;
    localparam int CARRY_NS  = 300;
    // least times round up to whole cycles
    localparam int BUSY_CYC  = (BUSY_NS * CLK_MHZ + 999) / 1000;
    localparam int CARRY_CYC = (CARRY_NS * CLK_MHZ + 999) / 1000;
    localparam int STR_W     = 8;

    // position word
    localparam int POS_W     = 16;
    localparam logic [15:0] POS_RST = 16'h0000;

    // resolution select codes and masks
    localparam logic [1:0]  RES_10 = 2'h0;
    localparam logic [1:0]  RES_12 = 2'h1;
    localparam logic [1:0]  RES_14 = 2'h2;
    localparam logic [1:0]  RES_16 = 2'h3;
    localparam logic [15:0] MASK_10 = 16'h03ff;
    localparam logic [15:0] MASK_12 = 16'h0fff;
    localparam logic [15:0] MASK_14 = 16'h3fff;
    localparam logic [15:0] MASK_16 = 16'hffff;

    // register bus
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_MASK   = 4'h1;
    localparam logic [3:0] OFS_COUNT  = 4'h2;
    localparam logic [3:0] OFS_LATCH  = 4'h3;
    localparam logic [3:0] OFS_INFO   = 4'h4;

    // status and mask bit positions
    localparam int ST_STEP  = 0;
    localparam int ST_CARRY = 1;
    localparam int ST_DIRCH = 2;
    localparam int ST_W     = 3;
    localparam logic [2:0] MASK_RST = 3'h0;

    // info register field positions
    localparam int INFO_RES_LO = 0;
    localparam int INFO_DIR    = 2;
    localparam int INFO_HOLD   = 3;

    // one decoded counter step
    typedef struct packed {
        logic step;
        logic up;
        logic wrap;
    } tpc_step_t;

    // register port request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } tpc_bus_req_t;
endpackage

/* File: hw/tpc_sync.sv */
`timescale 1ns/1ps
module tpc_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_ff;

    // two flops; first stage feeds only the second
    // no reset: the flops track the pins through reset, so a pin that
    // idles high does not look like a fresh edge once reset is gone
    always_ff @(posedge mclk_i) begin
        meta_ff <= d_i;
        q_o     <= meta_ff;
    end
endmodule // tpc_sync

/* File: hw/tpc_stretch.sv */
`timescale 1ns/1ps
module tpc_stretch #(
    parameter int CYC = 2
) (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic trig_i,
    output logic      pulse_o
);
    localparam logic [tpc_pkg::STR_W-1:0] LOAD =
        tpc_pkg::STR_W'(CYC - 1);

    logic [tpc_pkg::STR_W-1:0] cnt_ff;

    // retrigger restarts the full width
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cnt_ff  <= '0;
            pulse_o <= 1'b0;
        end else if (trig_i) begin
            cnt_ff  <= LOAD;
            pulse_o <= 1'b1;
        end else if (cnt_ff != '0) begin
            cnt_ff  <= cnt_ff - 1'b1;
        end else begin
            pulse_o <= 1'b0;
        end
    end
endmodule // tpc_stretch

/* File: verif/tpc_host_model.sv */
`timescale 1ns/1ps
// host side: select driver and external revolution counter
module tpc_host_model (
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic       busy_i,
    input  wire logic       carry_i,
    input  wire logic       dir_i,
    input  wire logic [1:0] sel_req_i,
    output logic      [1:0] sel_o,
    output logic      [7:0] revs_o,
    output logic      [7:0] carry_w_o
);
    logic       carry_ff;
    logic [7:0] run_ff;

    // select only idle
    // a request made while busy waits, so data never moves at the switch
    always_ff @(posedge mclk_i) begin
        if (rst_i || !busy_i) begin
            sel_o <= sel_req_i;
        end
    end

    // direction at carry
    // counts revolutions the way an external up-down counter would
    always_ff @(posedge mclk_i) begin
        carry_ff <= carry_i;
        if (rst_i) begin
            revs_o    <= 8'h00;
            run_ff    <= 8'h00;
            carry_w_o <= 8'h00;
        end else if (carry_i) begin
            run_ff <= run_ff + 8'h01;
            if (!carry_ff) begin
                revs_o <= dir_i ? revs_o + 8'h01 : revs_o - 8'h01;
            end
        end else if (carry_ff) begin
            carry_w_o <= run_ff; // width of the pulse just ended
            run_ff    <= 8'h00;
        end
    end
endmodule // tpc_host_model

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic        mclk_i, rst_i, step_up_i, step_dn_i, hold_n_i;
    logic        wr_i, rd_i, busy_o, carry_pulse_out_o, dir_o, irq_o;
    logic [3:0]  addr_i;
    logic [15:0] wdata_i, rdata_o, position_bits_o;
    logic [1:0]  sel, sel_req;
    logic [7:0]  revs, carry_w;
    logic        busy_q;
    int          failures, check_count, busy_n, b0;
    logic [15:0] masks [4];

    tpc_top i_tpc_top (
        .mclk_i(mclk_i), .rst_i(rst_i), .step_up_i(step_up_i),
        .step_dn_i(step_dn_i), .hold_n_i(hold_n_i),
        .res_select_a_i(sel[0]), .res_select_b_i(sel[1]),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .position_bits_o(position_bits_o),
        .busy_o(busy_o), .carry_pulse_out_o(carry_pulse_out_o),
        .dir_o(dir_o), .irq_o(irq_o)
    );

    tpc_host_model i_tpc_host_model (
        .mclk_i(mclk_i), .rst_i(rst_i), .busy_i(busy_o),
        .carry_i(carry_pulse_out_o), .dir_i(dir_o), .sel_req_i(sel_req),
        .sel_o(sel), .revs_o(revs), .carry_w_o(carry_w)
    );

    // 200 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    // busy pulse counter, one per rising edge of busy
    always @(posedge mclk_i) begin
        busy_q <= busy_o;
        if (busy_o && !busy_q) busy_n++;
    end

    task automatic end_of_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= v;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rchk(input logic [3:0] a, input logic [15:0] e);
        @(posedge mclk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        #1 chk(rdata_o, e);
    endtask

    // let a register write reach the interrupt line
    task automatic settle;
        repeat (2) @(posedge mclk_i);
        #1;
    endtask

    // pin pulse long enough for the sync, then wait out busy and carry
    task automatic step(input logic up);
        @(posedge mclk_i);
        if (up) step_up_i <= 1'b1;
        else step_dn_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        step_up_i <= 1'b0;
        step_dn_i <= 1'b0;
        repeat (70) @(posedge mclk_i);
    endtask

    // watchdog, the tests need a little over a thousand cycles
    initial begin
        #100000;
        failures++;
        end_of_test();
    end

    initial begin
        masks = '{tpc_pkg::MASK_10, tpc_pkg::MASK_12,
                  tpc_pkg::MASK_14, tpc_pkg::MASK_16};
        {step_up_i, step_dn_i, wr_i, rd_i} = 4'h0;
        hold_n_i = 1'b1;
        addr_i   = 4'h0;
        wdata_i  = 16'h0000;
        sel_req  = 2'h0;
        busy_q   = 1'b0;
        rst_i    = 1'b1;
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        chk(position_bits_o, 16'h0000);
        b0 = busy_n;
        step(1'b1);
        chk(16'(busy_n - b0), 16'h0001);
        rchk(tpc_pkg::OFS_COUNT, 16'h0001);
        chk(position_bits_o, 16'h0001);
        step(1'b0);
        step(1'b0);
        chk(position_bits_o, tpc_pkg::MASK_10);
        chk({15'h0000, dir_o}, 16'h0000);
        chk({8'h00, revs}, 16'h00ff);
        chk({15'h0000, carry_w >= 8'(tpc_pkg::CARRY_CYC)}, 16'h0001);
        // frozen latch while the counter wraps up
        hold_n_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        step(1'b1);
        chk(position_bits_o, tpc_pkg::MASK_10);
        rchk(tpc_pkg::OFS_COUNT, 16'h0000);
        rchk(tpc_pkg::OFS_LATCH, 16'h03ff);
        rchk(tpc_pkg::OFS_INFO, 16'h0004);
        chk({15'h0000, dir_o}, 16'h0001);
        chk({8'h00, revs}, 16'h0000);
        hold_n_i <= 1'b1;
        repeat (10) @(posedge mclk_i);
        chk(position_bits_o, 16'h0000);
        rchk(tpc_pkg::OFS_INFO, 16'h000c);
        rchk(tpc_pkg::OFS_LATCH, 16'h0000);
        // every select code, wrap down then up
        for (int i = 0; i < 4; i++) begin
            sel_req <= 2'(i);
            repeat (10) @(posedge mclk_i);
            step(1'b0);
            chk(position_bits_o, masks[i]);
            step(1'b1);
            chk(position_bits_o, 16'h0000);
        end
        chk({8'h00, revs}, 16'h0000);
        // interrupt raise, mask and clear
        wr(tpc_pkg::OFS_STATUS, 16'h0007);
        wr(tpc_pkg::OFS_MASK, 16'h0001);
        settle();
        chk({15'h0000, irq_o}, 16'h0000);
        step(1'b1);
        chk({15'h0000, irq_o}, 16'h0001);
        rchk(tpc_pkg::OFS_STATUS, 16'h0001);
        wr(tpc_pkg::OFS_MASK, 16'h0000);
        settle();
        chk({15'h0000, irq_o}, 16'h0000);
        wr(tpc_pkg::OFS_MASK, 16'h0001);
        rchk(tpc_pkg::OFS_MASK, 16'h0001);
        wr(tpc_pkg::OFS_STATUS, 16'h0001);
        settle();
        chk({15'h0000, irq_o}, 16'h0000);
        rchk(4'hf, 16'h0000);
        end_of_test();
    end
endmodule // tb_top
